// ===== pkg/fabric_pkg.sv
// Purpose: shared types and constants for the core bus fabric and ADC trigger path
// Assumes: one core clock for every bus; no software-visible registers in this block
// Notes: region bounds are word addresses on the primary data address bus

package fabric_pkg;

  localparam int ADDR_W = 24;
  localparam int PADDR_W = 21;
  localparam int WIDE_W = 32;
  localparam int NARROW_W = 16;
  localparam int ADDR_MSB = 23;
  localparam int TIMER_W = 16;

  localparam logic [23:0] DRAM_FIRST = 24'h000000;
  localparam logic [23:0] DRAM_LAST = 24'h001FFF;
  localparam logic [23:0] DFLASH_FIRST = 24'h004000;
  localparam logic [23:0] DFLASH_LAST = 24'h004FFF;
  localparam logic [23:0] PERIPH_FIRST = 24'h00F000;
  localparam logic [23:0] PERIPH_LAST = 24'h00FFFF;

  localparam logic TRIG_PERIODIC = 1'h0;
  localparam logic TRIG_DELAYED = 1'h1;
  localparam logic [15:0] TIMER_ONE = 16'h0001;
  localparam logic [15:0] TIMER_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } access_size_e;

  typedef enum logic [3:0] {
    TGT_DRAM = 4'h1,
    TGT_DFLASH = 4'h2,
    TGT_EXT = 4'h4,
    TGT_PERIPH = 4'h8
  } target_e;

  typedef enum logic [2:0] {
    TS_IDLE = 3'h1,
    TS_PERIODIC = 3'h2,
    TS_DELAY = 3'h4
  } trig_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    access_size_e size;
    logic [23:0] primary_data_address_bus;
    logic [31:0] wdata;
  } data_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [20:0] addr;
    logic [31:0] wdata;
  } prog_req_s;

  typedef struct packed {
    logic rd;
    logic [23:0] secondary_data_address_bus;
  } sec_req_s;

  typedef struct packed {
    logic rd;
    logic wr;
    access_size_e size;
    logic [23:0] addr;
    logic [31:0] wdata;
  } slave32_s;

  typedef struct packed {
    logic rd;
    logic wr;
    access_size_e size;
    logic [23:0] addr;
    logic [15:0] wdata;
  } slave16_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [20:0] addr;
    logic [15:0] wdata;
  } prog_slave_s;

endpackage

// ===== src/adc_trigger_timer.sv
// Purpose: timer channel that starts ADC conversions, periodic or delayed from PWM reload
// Assumes: PWM reload pulse comes from logic on CORE_CLK, one cycle wide
// Notes: period 0 gives no periodic pulses; a reload during a delay restarts it

`timescale 1ns/1ns

module adc_trigger_timer (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic enable, // channel runs
  input wire logic mode, // periodic or delayed
  input wire logic [15:0] period, // cycles between periodic pulses
  input wire logic [15:0] delay, // delay after reload pulse
  input wire logic pwm_reload, // reload pulse from PWM
  output logic start // conversion start pulse
);

  fabric_pkg::trig_state_e state_r, state_nxt;
  logic [15:0] count_r, count_nxt;
  logic start_r, start_nxt;

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    start_nxt = 1'b0;
    unique case (state_r)
      fabric_pkg::TS_IDLE: begin
        if (enable && mode == fabric_pkg::TRIG_PERIODIC && period != fabric_pkg::TIMER_ZERO) begin
          state_nxt = fabric_pkg::TS_PERIODIC;
          count_nxt = period - fabric_pkg::TIMER_ONE;
        end else if (enable && mode == fabric_pkg::TRIG_DELAYED && pwm_reload) begin
          state_nxt = fabric_pkg::TS_DELAY; // RQ2
          count_nxt = delay;
        end
      end
      fabric_pkg::TS_PERIODIC: begin
        if (!enable || mode != fabric_pkg::TRIG_PERIODIC || period == fabric_pkg::TIMER_ZERO) begin
          state_nxt = fabric_pkg::TS_IDLE;
        end else if (count_r == fabric_pkg::TIMER_ZERO) begin
          start_nxt = 1'b1; // RQ1
          count_nxt = period - fabric_pkg::TIMER_ONE;
        end else begin
          count_nxt = count_r - fabric_pkg::TIMER_ONE;
        end
      end
      fabric_pkg::TS_DELAY: begin
        if (!enable || mode != fabric_pkg::TRIG_DELAYED) begin
          state_nxt = fabric_pkg::TS_IDLE;
        end else if (pwm_reload) begin
          count_nxt = delay; // RQ3
        end else if (count_r == fabric_pkg::TIMER_ZERO) begin
          start_nxt = 1'b1; // RQ3
          state_nxt = fabric_pkg::TS_IDLE;
        end else begin
          count_nxt = count_r - fabric_pkg::TIMER_ONE;
        end
      end
      default: begin
        state_nxt = fabric_pkg::TS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= fabric_pkg::TS_IDLE;
      count_r <= fabric_pkg::TIMER_ZERO;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      start_r <= start_nxt;
    end
  end

  assign start = start_r;

endmodule

// ===== src/core_bus_fabric_adc_sync.sv
// Purpose: core bus fabric joining core to program, data, flash, external and peripheral targets
// Assumes: slaves return read data in the cycle after their strobe; one core clock
// Notes: every path has the same three-cycle read latency, peripherals included
// Overview of operation
// RQ1 - a timer channel can issue periodic ADC conversion start pulses.
// RQ2 - in delayed mode the PWM reload pulse feeds the timer instead of the ADC.
// RQ3 - after a reload pulse the timer waits the programmed delay, then starts the ADC.
// RQ4 - the data RAM port is 32 bits wide and every other memory data port 16 bits.
// RQ5 - flash control goes over the peripheral bus while flash data moves directly.
// RQ6 - program memory uses a 21-bit address and returns 16-bit words.
// RQ7 - program memory writes use only the low 16 bits of the core write bus.
// RQ8 - primary data reads return up to 32 bits on the core read bus.
// RQ9 - the primary address bus carries byte, word and long accesses.
// RQ10 - peripheral registers are decoded from the primary data address space.
// RQ11 - the secondary address bus reads words only and returns 16 bits.
// RQ12 - the peripheral bus runs at the data memory rate with no added cycles.
// RQ13 - peripheral writes take core write data and reads return on the core read bus.
// RQ14 - byte accesses have the top address bit forced to zero.
// RQ15 - each primary address goes to exactly one target.

`timescale 1ns/1ns

module core_bus_fabric_adc_sync (
  input wire logic CORE_CLK, // core clock, 20 MHz
  input wire logic RESET_N, // async reset, active low
  input fabric_pkg::prog_req_s CORE_PREQ, // program memory request
  output logic [15:0] CORE_PRDATA, // program read bus
  output logic CORE_PRVALID, // program read data valid
  input fabric_pkg::data_req_s CORE_XREQ, // primary data request
  output logic [31:0] CORE_RDATA, // core read bus
  output logic CORE_RVALID, // core read data valid
  input fabric_pkg::sec_req_s CORE_SREQ, // secondary read request
  output logic [15:0] CORE_SRDATA, // secondary read bus
  output logic CORE_SRVALID, // secondary read data valid
  output fabric_pkg::prog_slave_s PMEM_REQ, // program memory strobe
  input wire logic [15:0] PMEM_RDATA, // program memory read data
  output fabric_pkg::slave32_s DRAM_REQ, // data RAM primary port
  input wire logic [31:0] DRAM_RDATA, // data RAM read data
  output fabric_pkg::slave16_s DRAM2_REQ, // data RAM secondary port
  input wire logic [15:0] DRAM2_RDATA, // data RAM secondary read data
  output fabric_pkg::slave16_s DFLASH_REQ, // data flash array port
  input wire logic [15:0] DFLASH_RDATA, // data flash read data
  output fabric_pkg::slave16_s EXT_REQ, // external interface port
  input wire logic [15:0] EXT_RDATA, // external read data
  output fabric_pkg::slave16_s PERIPH_REQ, // peripheral register bus
  input wire logic [15:0] PERIPH_RDATA, // peripheral read data
  input wire logic TRIG_ENABLE, // trigger channel enable
  input wire logic TRIG_MODE, // periodic or delayed
  input wire logic [15:0] TRIG_PERIOD, // periodic interval
  input wire logic [15:0] TRIG_DELAY, // delay after reload
  input wire logic PWM_RELOAD, // PWM reload pulse
  output logic ADC_START // ADC conversion start pulse
);

  function automatic fabric_pkg::target_e decode(input logic [23:0] a);
    if (a >= fabric_pkg::DRAM_FIRST && a <= fabric_pkg::DRAM_LAST) begin
      decode = fabric_pkg::TGT_DRAM;
    end else if (a >= fabric_pkg::DFLASH_FIRST && a <= fabric_pkg::DFLASH_LAST) begin
      decode = fabric_pkg::TGT_DFLASH;
    end else if (a >= fabric_pkg::PERIPH_FIRST && a <= fabric_pkg::PERIPH_LAST) begin
      decode = fabric_pkg::TGT_PERIPH; // RQ10
    end else begin
      decode = fabric_pkg::TGT_EXT;
    end
  endfunction

  fabric_pkg::prog_slave_s pmem_r, pmem_nxt;
  fabric_pkg::slave32_s dram_r, dram_nxt;
  fabric_pkg::slave16_s dram2_r, dram2_nxt;
  fabric_pkg::slave16_s dflash_r, dflash_nxt;
  fabric_pkg::slave16_s ext_r, ext_nxt;
  fabric_pkg::slave16_s periph_r, periph_nxt;
  fabric_pkg::target_e tgt1_r, tgt1_nxt, tgt2_r, tgt2_nxt;
  logic xrd1_r, xrd1_nxt, xrd2_r, xrd2_nxt;
  logic prd1_r, prd1_nxt, prd2_r, prd2_nxt;
  logic srd1_r, srd1_nxt, srd2_r, srd2_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] prdata_r, prdata_nxt, srdata_r, srdata_nxt;
  logic rvalid_r, rvalid_nxt, prvalid_r, prvalid_nxt, srvalid_r, srvalid_nxt;
  logic [23:0] eff_addr;
  fabric_pkg::target_e tgt;
  logic xrd, xwr;

  always_comb begin
    eff_addr = CORE_XREQ.primary_data_address_bus;
    if (CORE_XREQ.size == fabric_pkg::SZ_BYTE) begin
      eff_addr[fabric_pkg::ADDR_MSB] = 1'b0; // RQ14
    end
    tgt = decode(eff_addr); // RQ15
    xrd = CORE_XREQ.valid && !CORE_XREQ.write;
    xwr = CORE_XREQ.valid && CORE_XREQ.write;

    // program side: 16-bit data, low half of write bus only
    pmem_nxt.rd = CORE_PREQ.rd; // RQ6
    pmem_nxt.wr = CORE_PREQ.wr && !CORE_PREQ.rd;
    pmem_nxt.addr = CORE_PREQ.addr; // RQ6
    pmem_nxt.wdata = CORE_PREQ.wdata[15:0]; // RQ7

    // every target sees the same fields; only its own strobe is set
    dram_nxt.rd = xrd && tgt == fabric_pkg::TGT_DRAM; // RQ15
    dram_nxt.wr = xwr && tgt == fabric_pkg::TGT_DRAM;
    dram_nxt.size = CORE_XREQ.size; // RQ9
    dram_nxt.addr = eff_addr;
    dram_nxt.wdata = CORE_XREQ.wdata; // RQ4
    dflash_nxt.rd = xrd && tgt == fabric_pkg::TGT_DFLASH; // RQ5
    dflash_nxt.wr = xwr && tgt == fabric_pkg::TGT_DFLASH;
    dflash_nxt.size = CORE_XREQ.size;
    dflash_nxt.addr = eff_addr;
    dflash_nxt.wdata = CORE_XREQ.wdata[15:0]; // RQ4
    ext_nxt.rd = xrd && tgt == fabric_pkg::TGT_EXT;
    ext_nxt.wr = xwr && tgt == fabric_pkg::TGT_EXT;
    ext_nxt.size = CORE_XREQ.size;
    ext_nxt.addr = eff_addr;
    ext_nxt.wdata = CORE_XREQ.wdata[15:0];
    periph_nxt.rd = xrd && tgt == fabric_pkg::TGT_PERIPH; // RQ12
    periph_nxt.wr = xwr && tgt == fabric_pkg::TGT_PERIPH; // RQ5
    periph_nxt.size = CORE_XREQ.size;
    periph_nxt.addr = eff_addr;
    periph_nxt.wdata = CORE_XREQ.wdata[15:0]; // RQ13

    // secondary port: words only, size field fixed
    dram2_nxt.rd = CORE_SREQ.rd; // RQ11
    dram2_nxt.wr = 1'b0;
    dram2_nxt.size = fabric_pkg::SZ_WORD; // RQ11
    dram2_nxt.addr = CORE_SREQ.secondary_data_address_bus;
    dram2_nxt.wdata = 16'h0000;

    // read return pipeline, equal depth for all targets
    xrd1_nxt = xrd;
    tgt1_nxt = xrd ? tgt : tgt1_r;
    xrd2_nxt = xrd1_r;
    tgt2_nxt = tgt1_r;
    prd1_nxt = CORE_PREQ.rd;
    prd2_nxt = prd1_r;
    srd1_nxt = CORE_SREQ.rd;
    srd2_nxt = srd1_r;

    rvalid_nxt = xrd2_r; // RQ12
    rdata_nxt = rdata_r;
    if (xrd2_r) begin
      unique case (tgt2_r)
        fabric_pkg::TGT_DRAM: rdata_nxt = DRAM_RDATA; // RQ8
        fabric_pkg::TGT_DFLASH: rdata_nxt = {16'h0000, DFLASH_RDATA};
        fabric_pkg::TGT_EXT: rdata_nxt = {16'h0000, EXT_RDATA};
        fabric_pkg::TGT_PERIPH: rdata_nxt = {16'h0000, PERIPH_RDATA}; // RQ13
      endcase
    end
    prvalid_nxt = prd2_r;
    prdata_nxt = prd2_r ? PMEM_RDATA : prdata_r; // RQ6
    srvalid_nxt = srd2_r;
    srdata_nxt = srd2_r ? DRAM2_RDATA : srdata_r; // RQ11
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pmem_r <= '0;
      dram_r <= '0;
      dram2_r <= '0;
      dflash_r <= '0;
      ext_r <= '0;
      periph_r <= '0;
      tgt1_r <= fabric_pkg::TGT_DRAM;
      tgt2_r <= fabric_pkg::TGT_DRAM;
      xrd1_r <= 1'b0;
      xrd2_r <= 1'b0;
      prd1_r <= 1'b0;
      prd2_r <= 1'b0;
      srd1_r <= 1'b0;
      srd2_r <= 1'b0;
      rdata_r <= 32'h00000000;
      prdata_r <= 16'h0000;
      srdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      prvalid_r <= 1'b0;
      srvalid_r <= 1'b0;
    end else begin
      pmem_r <= pmem_nxt;
      dram_r <= dram_nxt;
      dram2_r <= dram2_nxt;
      dflash_r <= dflash_nxt;
      ext_r <= ext_nxt;
      periph_r <= periph_nxt;
      tgt1_r <= tgt1_nxt;
      tgt2_r <= tgt2_nxt;
      xrd1_r <= xrd1_nxt;
      xrd2_r <= xrd2_nxt;
      prd1_r <= prd1_nxt;
      prd2_r <= prd2_nxt;
      srd1_r <= srd1_nxt;
      srd2_r <= srd2_nxt;
      rdata_r <= rdata_nxt;
      prdata_r <= prdata_nxt;
      srdata_r <= srdata_nxt;
      rvalid_r <= rvalid_nxt;
      prvalid_r <= prvalid_nxt;
      srvalid_r <= srvalid_nxt;
    end
  end

  // start output is the timer's own flip-flop
  adc_trigger_timer trig_timer (
    .clk(CORE_CLK),
    .reset_n(RESET_N),
    .enable(TRIG_ENABLE),
    .mode(TRIG_MODE),
    .period(TRIG_PERIOD),
    .delay(TRIG_DELAY),
    .pwm_reload(PWM_RELOAD),
    .start(ADC_START)
  );

  assign PMEM_REQ = pmem_r;
  assign DRAM_REQ = dram_r;
  assign DRAM2_REQ = dram2_r;
  assign DFLASH_REQ = dflash_r;
  assign EXT_REQ = ext_r;
  assign PERIPH_REQ = periph_r;
  assign CORE_RDATA = rdata_r;
  assign CORE_RVALID = rvalid_r;
  assign CORE_PRDATA = prdata_r;
  assign CORE_PRVALID = prvalid_r;
  assign CORE_SRDATA = srdata_r;
  assign CORE_SRVALID = srvalid_r;

endmodule

// ===== testbench/core_bus_fabric_adc_sync_test.sv
// Purpose: directed bench for the bus fabric and ADC trigger path
// Assumes: inputs change at the falling edge
// Notes: slave model answers every read strobe
`timescale 1ns/1ns
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin errors++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, w); end end
module core_bus_fabric_adc_sync_test;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  fabric_pkg::prog_req_s CORE_PREQ = '0;
  fabric_pkg::data_req_s CORE_XREQ = '0;
  fabric_pkg::sec_req_s CORE_SREQ = '0;
  fabric_pkg::prog_slave_s PMEM_REQ;
  fabric_pkg::slave32_s DRAM_REQ;
  fabric_pkg::slave16_s DRAM2_REQ, DFLASH_REQ, EXT_REQ, PERIPH_REQ;
  logic [15:0] CORE_PRDATA, CORE_SRDATA, PMEM_RDATA, DRAM2_RDATA, DFLASH_RDATA;
  logic [15:0] EXT_RDATA, PERIPH_RDATA;
  logic [31:0] CORE_RDATA, DRAM_RDATA;
  logic CORE_PRVALID, CORE_RVALID, CORE_SRVALID, ADC_START;
  logic TRIG_ENABLE = 1'b0, TRIG_MODE = 1'b0, PWM_RELOAD = 1'b0;
  logic [15:0] TRIG_PERIOD = 16'h0000, TRIG_DELAY = 16'h0000;
  int errors = 0, comparisons = 0, cycles = 0;
  core_bus_fabric_adc_sync dut (.CORE_CLK, .RESET_N, .CORE_PREQ, .CORE_PRDATA, .CORE_PRVALID,
    .CORE_XREQ, .CORE_RDATA, .CORE_RVALID, .CORE_SREQ, .CORE_SRDATA, .CORE_SRVALID,
    .PMEM_REQ, .PMEM_RDATA, .DRAM_REQ, .DRAM_RDATA, .DRAM2_REQ, .DRAM2_RDATA, .DFLASH_REQ,
    .DFLASH_RDATA, .EXT_REQ, .EXT_RDATA, .PERIPH_REQ, .PERIPH_RDATA, .TRIG_ENABLE,
    .TRIG_MODE, .TRIG_PERIOD, .TRIG_DELAY, .PWM_RELOAD, .ADC_START);
  slave_model mem (.CORE_CLK, .RESET_N, .PMEM_REQ, .DRAM_REQ, .DRAM2_REQ, .DFLASH_REQ,
    .EXT_REQ, .PERIPH_REQ, .PMEM_RDATA, .DRAM_RDATA, .DRAM2_RDATA, .DFLASH_RDATA,
    .EXT_RDATA, .PERIPH_RDATA);
  initial forever #25 CORE_CLK = ~CORE_CLK;
  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      summarize();
    end
  end
  task automatic data_op(input logic wr, input fabric_pkg::access_size_e sz,
      input logic [23:0] a, input logic [31:0] wd, input logic [3:0] tgt, input logic [31:0] rd);
    logic [1:0] sr;
    logic [1:0] ssz;
    logic [23:0] sx;
    logic [31:0] sw;
    CORE_XREQ = '{1'b1, wr, sz, a, wd};
    @(negedge CORE_CLK);
    CORE_XREQ.valid = 1'b0;
    case (tgt)
      4'h1: {sr, ssz, sx, sw} = {DRAM_REQ.rd, DRAM_REQ.wr, DRAM_REQ.size, DRAM_REQ.addr,
        DRAM_REQ.wdata};
      4'h2: {sr, ssz, sx, sw} = {DFLASH_REQ.rd, DFLASH_REQ.wr, DFLASH_REQ.size, DFLASH_REQ.addr,
        16'h0, DFLASH_REQ.wdata};
      4'h4: {sr, ssz, sx, sw} = {EXT_REQ.rd, EXT_REQ.wr, EXT_REQ.size, EXT_REQ.addr, 16'h0,
        EXT_REQ.wdata};
      default: {sr, ssz, sx, sw} = {PERIPH_REQ.rd, PERIPH_REQ.wr, PERIPH_REQ.size,
        PERIPH_REQ.addr, 16'h0, PERIPH_REQ.wdata};
    endcase
    `CHK(ssz, sz)
    `CHK({sr, sx}, {~wr, wr, sz == fabric_pkg::SZ_BYTE ? 1'b0 : a[23], a[22:0]})
    if (wr) `CHK(sw, tgt == 4'h1 ? wd : {16'h0000, wd[15:0]})
    repeat (2) @(negedge CORE_CLK);
    `CHK({CORE_RVALID, wr ? 32'h0 : CORE_RDATA}, {~wr, wr ? 32'h0 : rd})
  endtask
  task automatic prog_op(input logic rd, input logic wr, input logic [20:0] a,
      input logic [31:0] wd);
    CORE_PREQ = '{rd, wr, a, wd};
    @(negedge CORE_CLK);
    CORE_PREQ = '0;
    `CHK({PMEM_REQ.rd, PMEM_REQ.wr, PMEM_REQ.addr}, {rd, wr & ~rd, a})
    if (wr & ~rd) `CHK(PMEM_REQ.wdata, wd[15:0])
    repeat (2) @(negedge CORE_CLK);
    `CHK({CORE_PRVALID, rd ? CORE_PRDATA : 16'h0}, {rd, rd ? a[15:0] ^ 16'h5555 : 16'h0})
  endtask
  task automatic sec_op(input logic [23:0] a);
    CORE_SREQ = '{1'b1, a};
    @(negedge CORE_CLK);
    CORE_SREQ = '0;
    `CHK({DRAM2_REQ.rd, DRAM2_REQ.wr, DRAM2_REQ.size, DRAM2_REQ.addr}, {2'b10, fabric_pkg::SZ_WORD, a})
    repeat (2) @(negedge CORE_CLK);
    `CHK({CORE_SRVALID, CORE_SRDATA}, {1'b1, a[15:0] ^ 16'h4444})
  endtask
  task automatic periodic_run(input int p);
    int i;
    TRIG_PERIOD = p[15:0];
    TRIG_MODE = 1'b0;
    TRIG_ENABLE = 1'b1;
    i = 0;
    while (ADC_START !== 1'b1 && i < 40) begin
      @(negedge CORE_CLK);
      i++;
    end
    `CHK(i, p + 1)
    for (i = 0; i < 3 * p; i++) begin
      @(negedge CORE_CLK);
      `CHK(ADC_START, i % p == p - 1)
    end
    TRIG_ENABLE = 1'b0;
  endtask
  task automatic delayed_run(input int d);
    int i;
    TRIG_DELAY = d[15:0];
    TRIG_MODE = 1'b1;
    TRIG_ENABLE = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    PWM_RELOAD = 1'b1;
    @(negedge CORE_CLK);
    PWM_RELOAD = 1'b0;
    @(negedge CORE_CLK);
    // second reload restarts the wait, so only one pulse may follow
    PWM_RELOAD = 1'b1;
    for (i = 3; i <= d + 6; i++) begin
      @(negedge CORE_CLK);
      PWM_RELOAD = 1'b0;
      `CHK(ADC_START, i == d + 4)
    end
    TRIG_ENABLE = 1'b0;
  endtask
  initial begin
    repeat (12) @(negedge CORE_CLK);
    RESET_N = 1'b1;
    @(negedge CORE_CLK);
    fork
      data_op(1'b0, fabric_pkg::SZ_WORD, 24'h000010, 32'h0, 4'h1, 32'hD0000010);
      sec_op(24'h000123);
    join
    data_op(1'b0, fabric_pkg::SZ_BYTE, 24'h801FFF, 32'h0, 4'h1, 32'hD0001FFF);
    data_op(1'b0, fabric_pkg::SZ_LONG, 24'h004000, 32'h0, 4'h2, 32'h00005111);
    data_op(1'b0, fabric_pkg::SZ_WORD, 24'h00F004, 32'h0, 4'h8, 32'h0000C337);
    data_op(1'b0, fabric_pkg::SZ_WORD, 24'h00EFFF, 32'h0, 4'h4, 32'h0000CDDD);
    data_op(1'b1, fabric_pkg::SZ_LONG, 24'h000020, 32'hCAFE1234, 4'h1, 32'h0);
    data_op(1'b1, fabric_pkg::SZ_WORD, 24'h00F010, 32'hBEEF5678, 4'h8, 32'h0);
    data_op(1'b1, fabric_pkg::SZ_BYTE, 24'h80F011, 32'h000000AB, 4'h8, 32'h0);
    prog_op(1'b1, 1'b0, 21'h1FFFFF, 32'h0);
    prog_op(1'b0, 1'b1, 21'h000100, 32'hDEAD1234);
    prog_op(1'b1, 1'b1, 21'h000ABC, 32'h0);
    periodic_run(3);
    repeat (3) @(negedge CORE_CLK);
    delayed_run(4);
    summarize();
  end
endmodule

// ===== testbench/fabric_sva.sv
// Purpose: port checker for the bus fabric and ADC trigger path
// Assumes: one core clock, asynchronous active-low reset
// Notes: bound to every fabric instance
`timescale 1ns/1ns
module fabric_checker (
  input wire logic CORE_CLK, // core clock
  input wire logic RESET_N, // reset, active low
  input fabric_pkg::prog_req_s CORE_PREQ, // program request
  input wire logic CORE_PRVALID, // program read valid
  input fabric_pkg::data_req_s CORE_XREQ, // primary request
  input wire logic CORE_RVALID, // primary read valid
  input fabric_pkg::sec_req_s CORE_SREQ, // secondary request
  input fabric_pkg::prog_slave_s PMEM_REQ, // program strobe
  input fabric_pkg::slave32_s DRAM_REQ, // data RAM strobe
  input fabric_pkg::slave16_s DRAM2_REQ, // secondary strobe
  input fabric_pkg::slave16_s DFLASH_REQ, // flash strobe
  input fabric_pkg::slave16_s EXT_REQ, // external strobe
  input fabric_pkg::slave16_s PERIPH_REQ, // peripheral strobe
  input wire logic TRIG_ENABLE, // trigger enable
  input wire logic TRIG_MODE, // trigger mode
  input wire logic PWM_RELOAD, // reload pulse
  input wire logic ADC_START // conversion start
);
  logic [3:0] stb;
  logic hi_bit;
  assign stb = {PERIPH_REQ.rd | PERIPH_REQ.wr, EXT_REQ.rd | EXT_REQ.wr,
    DFLASH_REQ.rd | DFLASH_REQ.wr, DRAM_REQ.rd | DRAM_REQ.wr};
  assign hi_bit = |(stb & {PERIPH_REQ.addr[23], EXT_REQ.addr[23], DFLASH_REQ.addr[23],
    DRAM_REQ.addr[23]});
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  a_read_latency: assert property (CORE_XREQ.valid && !CORE_XREQ.write |-> ##3 CORE_RVALID)
    else $error("primary read answer late");
  a_one_target: assert property (CORE_XREQ.valid |=> $onehot(stb))
    else $error("primary access not on exactly one target");
  a_byte_low: assert property (CORE_XREQ.valid && CORE_XREQ.size == fabric_pkg::SZ_BYTE |=> !hi_bit)
    else $error("byte access kept top address bit");
  a_wide_port: assert property (DRAM_REQ.wr |-> DRAM_REQ.wdata == $past(CORE_XREQ.wdata))
    else $error("data RAM write data not full width");
  a_periph_wdata: assert property (PERIPH_REQ.wr |-> PERIPH_REQ.wdata == $past(CORE_XREQ.wdata[15:0]))
    else $error("peripheral write data wrong");
  a_prog_low: assert property (PMEM_REQ.wr |-> PMEM_REQ.wdata == $past(CORE_PREQ.wdata[15:0]))
    else $error("program write data not low half");
  a_prog_latency: assert property (CORE_PREQ.rd |-> ##3 CORE_PRVALID)
    else $error("program read answer late");
  a_sec_word: assert property (CORE_SREQ.rd |=> DRAM2_REQ.rd && !DRAM2_REQ.wr &&
    DRAM2_REQ.size == fabric_pkg::SZ_WORD)
    else $error("secondary access not a word read");
  a_reload_routed: assert property (TRIG_ENABLE && TRIG_MODE && PWM_RELOAD |=> !ADC_START)
    else $error("reload reached converter directly");
  c_read: cover property (CORE_RVALID);
  c_delayed: cover property (TRIG_MODE && ADC_START);
  c_prog_write: cover property (PMEM_REQ.wr);
endmodule

bind core_bus_fabric_adc_sync fabric_checker u_chk (.CORE_CLK, .RESET_N, .CORE_PREQ,
  .CORE_PRVALID, .CORE_XREQ, .CORE_RVALID, .CORE_SREQ, .PMEM_REQ, .DRAM_REQ, .DRAM2_REQ,
  .DFLASH_REQ, .EXT_REQ, .PERIPH_REQ, .TRIG_ENABLE, .TRIG_MODE, .PWM_RELOAD, .ADC_START);

// ===== testbench/slave_model.sv
// Purpose: memory and peripheral slaves behind the fabric
// Assumes: read data due in the cycle after a read strobe
// Notes: data is a fixed mix of the address; writes are only absorbed
`timescale 1ns/1ns
module slave_model (
  input wire logic CORE_CLK, // core clock
  input wire logic RESET_N, // reset, active low
  input fabric_pkg::prog_slave_s PMEM_REQ, // program strobe, low half only
  input fabric_pkg::slave32_s DRAM_REQ, // data RAM strobe
  input fabric_pkg::slave16_s DRAM2_REQ, // secondary strobe
  input fabric_pkg::slave16_s DFLASH_REQ, // flash strobe
  input fabric_pkg::slave16_s EXT_REQ, // external strobe
  input fabric_pkg::slave16_s PERIPH_REQ, // peripheral strobe
  output logic [15:0] PMEM_RDATA, // program data
  output logic [31:0] DRAM_RDATA, // data RAM data
  output logic [15:0] DRAM2_RDATA, // secondary data
  output logic [15:0] DFLASH_RDATA, // flash data
  output logic [15:0] EXT_RDATA, // external data
  output logic [15:0] PERIPH_RDATA // peripheral data
);
  // idle lines toggle so a stale sample never matches
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {PMEM_RDATA, DRAM_RDATA, DRAM2_RDATA, DFLASH_RDATA, EXT_RDATA, PERIPH_RDATA} <= '0;
    end else begin
      PMEM_RDATA <= PMEM_REQ.rd ? PMEM_REQ.addr[15:0] ^ 16'h5555 : ~PMEM_RDATA;
      DRAM_RDATA <= DRAM_REQ.rd ? {8'hD0, DRAM_REQ.addr} : ~DRAM_RDATA;
      DRAM2_RDATA <= DRAM2_REQ.rd ? DRAM2_REQ.addr[15:0] ^ 16'h4444 : ~DRAM2_RDATA;
      DFLASH_RDATA <= DFLASH_REQ.rd ? DFLASH_REQ.addr[15:0] ^ 16'h1111 : ~DFLASH_RDATA;
      EXT_RDATA <= EXT_REQ.rd ? EXT_REQ.addr[15:0] ^ 16'h2222 : ~EXT_RDATA;
      PERIPH_RDATA <= PERIPH_REQ.rd ? PERIPH_REQ.addr[15:0] ^ 16'h3333 : ~PERIPH_RDATA;
    end
  end
endmodule
